// ---- pid_cfg.svh ----
// Constants for the process controller: indices, reset values, codes, scales
`ifndef PID_CFG_SVH
`define PID_CFG_SVH
// Parameter indices within the controller group
`define IDX_SP_SEL 8'h00
`define IDX_FB_SEL 8'h01
`define IDX_SP_INT 8'h02
`define IDX_MODE 8'h03
`define IDX_FB_GAIN 8'h04
`define IDX_KP 8'h05
`define IDX_TI 8'h06
`define IDX_TD 8'h07
`define IDX_BIAS 8'h09
`define IDX_LAG 8'h0a
`define IDX_I_LIM 8'h0e
`define IDX_O_LIM 8'h17
`define IDX_O_GAIN 8'h18
`define IDX_REV 8'h19
`define IDX_RAMP 8'h1a
`define IDX_DISP_MAX 8'h21
`define IDX_DISP_DEC 8'h22
`define IDX_DISP_UNIT 8'h23
`define IDX_DISP_VAL 8'h26
`define IDX_STATUS 8'h28
`define IDX_REF 8'h29
// Source codes
`define SRC_AI1 16'h0001
`define SRC_AI2 16'h0002
`define SRC_PULSE 16'h0003
`define SRC_INT 16'h0004
`define SRC_RSVD 16'h0005
`define SRC_FREQ 16'h0006
// Mode word bits
`define MODE_EN 0
`define MODE_NEG 1
`define MODE_DFB 2
`define MODE_ADD 3
// Reset values
`define RST_SP_SEL 16'h0001
`define RST_FB_SEL 16'h0002
`define RST_UNITY 16'h0064
`define RST_TI 16'h000a
`define RST_I_LIM 16'h03e8
`define RST_O_LIM 16'h2710
`define RST_O_GAIN 16'h000a
`define RST_DISP_MAX 16'h03e8
`define RST_DISP_DEC 16'h0001
// Scales: full scale 100.00 %, gains in hundredths, tenths
`define PCT_FULL 32'h0000_2710
`define HUNDRED 32'h0000_0064
`define TEN 32'h0000_000a
// Sample period of the loop
`define CLK_MHZ 200
`define SAMPLE_US 1000
`endif

// ---- pid_pkg.sv ----
// Types shared by the process controller
`default_nettype none
package pid_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] data;
  } param_req_type;
  typedef struct packed {
    logic [15:0] sp_sel, fb_sel, sp_int, mode, fb_gain, kp, ti, td;
    logic [15:0] bias, lag, i_lim, o_lim, o_gain, rev, ramp;
    logic [15:0] disp_max, disp_dec, disp_unit;
  } cfg_type;
  typedef struct packed {
    cfg_type cfg;
    logic [31:0] tick_cnt;
    logic signed [31:0] pulse_filt, sp_ramp, i_acc, d_prev, lag_y, cap, ref_out;
    logic [31:0] disp;
    logic [15:0] rd_data;
    logic run_d, alarm, active;
  } state_type;
endpackage
`default_nettype wire

// ---- pid_process_controller.sv ----
// Closed-loop process controller feeding the drive frequency reference
`default_nettype none
`include "pid_cfg.svh"

// Overview of operation
// - Setpoint source code: 1 analog one, 2 analog two, 3 pulse, 4 internal, 6 frequency.
// - Analog setpoint scales linearly, full input span to full percentage span.
// - Feedback source code: 1 analog one, 2 analog two, 3 pulse input.
// - Same input for setpoint and feedback is refused and raises conflict alarm.
// - Code 4 uses stored setpoint, 0 to 100.00 percent in hundredths.
// - Mode bit 0 enables the controller; clear disables it.
// - Mode bit 1 set: negative error raises frequency; clear: lowers it.
// - Mode bit 2 picks derivative input: error when clear, feedback when set.
// - Mode bit 3 clear: output alone, full output equals maximum frequency.
// - Mode bit 3 set: frequency command captured at run start plus output.
// - Error times proportional gain in hundredths.
// - Error integrated over integral time in tenths; longer time, slower response.
// - Derivative: rate of selected input times differential time, added to sum.
// - Negative output forced to zero unless reverse permission is 1.
// - Setpoint ramps to new value over ramp time in tenths of seconds; ramp settings above 100 step at once.
// - Output passes a first-order lag with configurable time constant.
// - Pulse setpoint is scaled and filtered by pulse scale and filter settings.
// - Setpoint shown scaled to engineering maximum, editable in that form.
// - Code 6 uses present frequency command, proportionally, as setpoint.
// - Integral term clamped to a configurable percentage limit.
// - Output clamped to configurable limit; lag applied after this clamp.
// - Signed bias added to frequency reference, scaled by output gain.
// - Feedback multiplied by configurable feedback gain before the error.
module pid_process_controller
  import pid_pkg::*;
#(
  parameter int ADC_W = 12,
  parameter int SAMPLE_CYCLES = `SAMPLE_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Parameter access
  input wire param_req_type param_req,
  output logic [15:0] param_rd_data,
  // Process inputs
  input wire logic [ADC_W-1:0] analog_input_one,
  input wire logic [ADC_W-1:0] analog_input_two,
  input wire logic [15:0] pulse_input,
  input wire logic [15:0] pulse_full_rate,
  input wire logic [3:0] pulse_filter_shift,
  // Drive side
  input wire logic run,
  input wire logic [15:0] freq_cmd,
  output logic signed [15:0] freq_ref,
  output logic pid_active,
  output logic source_conflict_alarm,
  output logic [31:0] display_value,
  output logic [15:0] display_decimals,
  output logic [15:0] display_unit
);
  // Largest analog code, taken as 100.00 %
  localparam logic signed [31:0] ADC_FULL = 32'(2 ** ADC_W - 1);

  state_type st_reg, st_next;

  function automatic logic signed [31:0] u16(input logic [15:0] v);
    u16 = $signed({16'h0000, v});
  endfunction

  // Zero divisor gives zero so unset times never stall the loop
  function automatic logic signed [31:0] div_safe(input logic signed [31:0] a,
                                                  input logic signed [31:0] b);
    div_safe = (b == 0) ? 32'sh0000_0000 : a / b;
  endfunction

  // Symmetric clamp to plus or minus lim
  function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                             input logic signed [31:0] lim);
    if (v > lim) begin
      sat = lim;
    end else if (v < -lim) begin
      sat = -lim;
    end else begin
      sat = v;
    end
  endfunction

  // Analog code to hundredths of a percent
  function automatic logic signed [31:0] adc_pct(input logic [ADC_W-1:0] v);
    adc_pct = div_safe($signed({{(32 - ADC_W){1'b0}}, v}) * `PCT_FULL, ADC_FULL);
  endfunction

  // Source decode shared by setpoint and feedback
  function automatic logic signed [31:0] pick(input logic [15:0] code,
                                              input logic [ADC_W-1:0] a1,
                                              input logic [ADC_W-1:0] a2,
                                              input logic signed [31:0] pls);
    if (code == `SRC_AI1) begin
      pick = adc_pct(a1);
    end else if (code == `SRC_AI2) begin
      pick = adc_pct(a2);
    end else if (code == `SRC_PULSE) begin
      pick = pls;
    end else begin
      pick = 32'sh0000_0000;
    end
  endfunction

  always_comb begin
    logic signed [31:0] sp_raw;
    logic signed [31:0] fb;
    logic signed [31:0] err;
    logic signed [31:0] p_t;
    logic signed [31:0] i_t;
    logic signed [31:0] d_in;
    logic signed [31:0] d_t;
    logic signed [31:0] sum;
    logic signed [31:0] ti_ms;
    logic signed [31:0] acc_lim;
    logic signed [31:0] step;
    logic signed [31:0] pls_pct;
    logic signed [31:0] lagged;
    logic signed [31:0] tau;
    logic tick;
    logic en;
    sp_raw = '0;
    fb = '0;
    err = '0;
    p_t = '0;
    i_t = '0;
    d_in = '0;
    d_t = '0;
    sum = '0;
    ti_ms = '0;
    acc_lim = '0;
    step = '0;
    pls_pct = '0;
    lagged = '0;
    tau = '0;
    tick = 1'b0;
    en = 1'b0;
    st_next = st_reg;

    // One loop sample every SAMPLE_CYCLES clocks
    tick = (st_reg.tick_cnt == 32'(SAMPLE_CYCLES - 1));
    st_next.tick_cnt = tick ? 32'h0000_0000 : st_reg.tick_cnt + 32'h0000_0001;

    // Parameter writes
    if (param_req.wr) begin
      if (param_req.addr == `IDX_SP_SEL) begin
        // Refused write keeps the old source
        if (param_req.data == st_reg.cfg.fb_sel) begin
          st_next.alarm = 1'b1;
        end else if (param_req.data >= `SRC_AI1 && param_req.data <= `SRC_FREQ &&
                     param_req.data != `SRC_RSVD) begin
          st_next.cfg.sp_sel = param_req.data;
          st_next.alarm = 1'b0;
        end
      end else if (param_req.addr == `IDX_FB_SEL) begin
        // Same check from the feedback side
        if (param_req.data == st_reg.cfg.sp_sel) begin
          st_next.alarm = 1'b1;
        end else if (param_req.data >= `SRC_AI1 && param_req.data <= `SRC_PULSE) begin
          st_next.cfg.fb_sel = param_req.data;
          st_next.alarm = 1'b0;
        end
      end else if (param_req.addr == `IDX_SP_INT) begin
        // Stored setpoint limited to full scale
        st_next.cfg.sp_int = 16'(sat(u16(param_req.data), `PCT_FULL));
      end else if (param_req.addr == `IDX_MODE) begin
        st_next.cfg.mode = param_req.data;
      end else if (param_req.addr == `IDX_FB_GAIN) begin
        st_next.cfg.fb_gain = param_req.data;
      end else if (param_req.addr == `IDX_KP) begin
        st_next.cfg.kp = param_req.data;
      end else if (param_req.addr == `IDX_TI) begin
        st_next.cfg.ti = param_req.data;
      end else if (param_req.addr == `IDX_TD) begin
        st_next.cfg.td = param_req.data;
      end else if (param_req.addr == `IDX_BIAS) begin
        st_next.cfg.bias = param_req.data;
      end else if (param_req.addr == `IDX_LAG) begin
        st_next.cfg.lag = param_req.data;
      end else if (param_req.addr == `IDX_I_LIM) begin
        st_next.cfg.i_lim = param_req.data;
      end else if (param_req.addr == `IDX_O_LIM) begin
        st_next.cfg.o_lim = param_req.data;
      end else if (param_req.addr == `IDX_O_GAIN) begin
        st_next.cfg.o_gain = param_req.data;
      end else if (param_req.addr == `IDX_REV) begin
        st_next.cfg.rev = param_req.data;
      end else if (param_req.addr == `IDX_RAMP) begin
        st_next.cfg.ramp = param_req.data;
      end else if (param_req.addr == `IDX_DISP_MAX) begin
        st_next.cfg.disp_max = param_req.data;
      end else if (param_req.addr == `IDX_DISP_DEC) begin
        st_next.cfg.disp_dec = param_req.data;
      end else if (param_req.addr == `IDX_DISP_UNIT) begin
        st_next.cfg.disp_unit = param_req.data;
      end else if (param_req.addr == `IDX_DISP_VAL) begin
        // Engineering value back to percentage
        st_next.cfg.sp_int = 16'(sat(div_safe(u16(param_req.data) * `PCT_FULL,
                                              u16(st_reg.cfg.disp_max)),
                                     `PCT_FULL));
      end
    end

    // Read-back, one cycle after the address
    if (param_req.addr == `IDX_SP_SEL) begin
      st_next.rd_data = st_reg.cfg.sp_sel;
    end else if (param_req.addr == `IDX_FB_SEL) begin
      st_next.rd_data = st_reg.cfg.fb_sel;
    end else if (param_req.addr == `IDX_SP_INT) begin
      st_next.rd_data = st_reg.cfg.sp_int;
    end else if (param_req.addr == `IDX_MODE) begin
      st_next.rd_data = st_reg.cfg.mode;
    end else if (param_req.addr == `IDX_FB_GAIN) begin
      st_next.rd_data = st_reg.cfg.fb_gain;
    end else if (param_req.addr == `IDX_KP) begin
      st_next.rd_data = st_reg.cfg.kp;
    end else if (param_req.addr == `IDX_TI) begin
      st_next.rd_data = st_reg.cfg.ti;
    end else if (param_req.addr == `IDX_TD) begin
      st_next.rd_data = st_reg.cfg.td;
    end else if (param_req.addr == `IDX_BIAS) begin
      st_next.rd_data = st_reg.cfg.bias;
    end else if (param_req.addr == `IDX_LAG) begin
      st_next.rd_data = st_reg.cfg.lag;
    end else if (param_req.addr == `IDX_I_LIM) begin
      st_next.rd_data = st_reg.cfg.i_lim;
    end else if (param_req.addr == `IDX_O_LIM) begin
      st_next.rd_data = st_reg.cfg.o_lim;
    end else if (param_req.addr == `IDX_O_GAIN) begin
      st_next.rd_data = st_reg.cfg.o_gain;
    end else if (param_req.addr == `IDX_REV) begin
      st_next.rd_data = st_reg.cfg.rev;
    end else if (param_req.addr == `IDX_RAMP) begin
      st_next.rd_data = st_reg.cfg.ramp;
    end else if (param_req.addr == `IDX_DISP_MAX) begin
      st_next.rd_data = st_reg.cfg.disp_max;
    end else if (param_req.addr == `IDX_DISP_DEC) begin
      st_next.rd_data = st_reg.cfg.disp_dec;
    end else if (param_req.addr == `IDX_DISP_UNIT) begin
      st_next.rd_data = st_reg.cfg.disp_unit;
    end else if (param_req.addr == `IDX_DISP_VAL) begin
      st_next.rd_data = st_reg.disp[15:0];
    end else if (param_req.addr == `IDX_STATUS) begin
      st_next.rd_data = {14'h0000, st_reg.alarm, st_reg.active};
    end else if (param_req.addr == `IDX_REF) begin
      st_next.rd_data = st_reg.ref_out[15:0];
    end else begin
      st_next.rd_data = 16'h0000;
    end

    // Display scaling of the stored setpoint
    st_next.disp = 32'(div_safe(u16(st_reg.cfg.sp_int) * u16(st_reg.cfg.disp_max),
                                `PCT_FULL));

    // Frequency command captured at run start
    st_next.run_d = run;
    if (run && !st_reg.run_d) begin
      st_next.cap = u16(freq_cmd);
    end

    // Conflict alarm blocks the loop as well as the mode bit
    en = st_reg.cfg.mode[`MODE_EN] && !st_reg.alarm;
    st_next.active = en;

    // Pulse rate as a percentage of its full rate
    pls_pct = sat(div_safe(u16(pulse_input) * `PCT_FULL, u16(pulse_full_rate)),
                  `PCT_FULL);

    // Setpoint source
    if (st_reg.cfg.sp_sel == `SRC_INT) begin
      sp_raw = u16(st_reg.cfg.sp_int);
    end else if (st_reg.cfg.sp_sel == `SRC_FREQ) begin
      sp_raw = sat(u16(freq_cmd), `PCT_FULL);
    end else begin
      sp_raw = pick(st_reg.cfg.sp_sel, analog_input_one, analog_input_two,
                    st_reg.pulse_filt);
    end

    // Feedback source, scaled by its gain
    fb = div_safe(pick(st_reg.cfg.fb_sel, analog_input_one, analog_input_two,
                       st_reg.pulse_filt) * u16(st_reg.cfg.fb_gain), `HUNDRED);

    if (tick) begin
      st_next.pulse_filt = st_reg.pulse_filt +
                           ((pls_pct - st_reg.pulse_filt) >>> pulse_filter_shift);
      // Disabled: reference follows the command within full scale
      if (!en) begin
        st_next.i_acc = '0;
        st_next.d_prev = '0;
        st_next.lag_y = '0;
        st_next.sp_ramp = sp_raw;
        st_next.ref_out = sat(u16(freq_cmd), `PCT_FULL);
      end else begin
        // Ramp step per sample: full scale over ramp time, full scale when that rounds to zero
        step = div_safe(`PCT_FULL, u16(st_reg.cfg.ramp) * `HUNDRED);
        if (st_reg.cfg.ramp == 16'h0000 || step == 0) begin
          step = `PCT_FULL;
        end
        st_next.sp_ramp = st_reg.sp_ramp + sat(sp_raw - st_reg.sp_ramp, step);

        // Error against the ramped setpoint
        err = st_next.sp_ramp - fb;
        p_t = div_safe(err * u16(st_reg.cfg.kp), `HUNDRED);

        // Integrator limit scales with the integral time
        ti_ms = u16(st_reg.cfg.ti) * `HUNDRED;
        acc_lim = u16(st_reg.cfg.i_lim) * `TEN * ti_ms;
        st_next.i_acc = sat(st_reg.i_acc + err, acc_lim);
        i_t = div_safe(st_next.i_acc, ti_ms);

        // Feedback input is negated so both inputs share one sign
        d_in = st_reg.cfg.mode[`MODE_DFB] ? -fb : err;
        d_t = (d_in - st_reg.d_prev) * u16(st_reg.cfg.td) * `TEN;
        st_next.d_prev = d_in;

        // Sum, polarity, limit and reverse permission
        sum = p_t + i_t + d_t;
        if (st_reg.cfg.mode[`MODE_NEG]) begin
          sum = -sum;
        end
        sum = sat(sum, sat(u16(st_reg.cfg.o_lim), `PCT_FULL));
        if (sum < 0 && st_reg.cfg.rev != 16'h0001) begin
          sum = '0;
        end

        // Output lag after the limit
        tau = u16(st_reg.cfg.lag) * `TEN;
        lagged = (tau == 0) ? sum :
                 st_reg.lag_y + div_safe(sum - st_reg.lag_y, tau);
        st_next.lag_y = lagged;

        // Captured command and bias are added after the lag
        if (st_reg.cfg.mode[`MODE_ADD]) begin
          lagged = lagged + st_reg.cap;
        end
        lagged = lagged + $signed({{16{st_reg.cfg.bias[15]}}, st_reg.cfg.bias}) *
                 u16(st_reg.cfg.o_gain) * `TEN;
        st_next.ref_out = sat(lagged, `PCT_FULL);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Power-on parameter defaults
      st_reg <= '0;
      st_reg.cfg.sp_sel <= `RST_SP_SEL;
      st_reg.cfg.fb_sel <= `RST_FB_SEL;
      st_reg.cfg.fb_gain <= `RST_UNITY;
      st_reg.cfg.kp <= `RST_UNITY;
      st_reg.cfg.ti <= `RST_TI;
      st_reg.cfg.i_lim <= `RST_I_LIM;
      st_reg.cfg.o_lim <= `RST_O_LIM;
      st_reg.cfg.o_gain <= `RST_O_GAIN;
      st_reg.cfg.disp_max <= `RST_DISP_MAX;
      st_reg.cfg.disp_dec <= `RST_DISP_DEC;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign param_rd_data = st_reg.rd_data;
  assign freq_ref = st_reg.ref_out[15:0];
  assign pid_active = st_reg.active;
  assign source_conflict_alarm = st_reg.alarm;
  assign display_value = st_reg.disp;
  assign display_decimals = st_reg.cfg.disp_dec;
  assign display_unit = st_reg.cfg.disp_unit;
endmodule
`default_nettype wire

// ---- pid_process_controller_asserts.sv ----
// Port-level checker for the process controller
`default_nettype none
`include "pid_cfg.svh"
module pid_process_controller_asserts
  import pid_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Parameter access
  input wire param_req_type param_req,
  input wire logic [15:0] param_rd_data,
  // Drive side
  input wire logic [15:0] freq_cmd,
  input wire logic signed [15:0] freq_ref,
  input wire logic pid_active,
  input wire logic source_conflict_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [15:0] REF_MAX = 16'sh2710;
  logic [31:0] tick_reg;
  logic tick;
  // Mirrors the loop sample counter
  assign tick = (tick_reg == 32'(SAMPLE_CYCLES - 1));
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) tick_reg <= 32'h0000_0000;
    else tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ref_hold_a: assert property ($changed(freq_ref) |-> $past(tick))
    else $error("reference moved between samples");
  bypass_pass_a: assert property (tick && freq_cmd <= 16'h2710 ##1 !pid_active
    |-> freq_ref == $signed($past(freq_cmd)))
    else $error("disabled loop did not pass the command");
  ref_clamp_a: assert property (freq_ref <= REF_MAX && freq_ref >= -REF_MAX)
    else $error("reference outside full scale");
  alarm_cause_a: assert property ($rose(source_conflict_alarm) |-> $past(param_req.wr)
    && $past(param_req.addr) inside {`IDX_SP_SEL, `IDX_FB_SEL})
    else $error("alarm rose without a source write");
  alarm_clear_a: assert property ($fell(source_conflict_alarm) |-> $past(param_req.wr)
    && $past(param_req.addr) inside {`IDX_SP_SEL, `IDX_FB_SEL})
    else $error("alarm fell without a source write");
  alarm_block_a: assert property (source_conflict_alarm
    && $past(source_conflict_alarm) |-> !pid_active)
    else $error("loop active during source conflict");
  kp_readback_a: assert property (param_req.wr && param_req.addr == `IDX_KP
    && param_req.data <= 16'h03e8 ##1 !param_req.wr && param_req.addr == `IDX_KP
    |=> param_rd_data == $past(param_req.data, 2))
    else $error("gain read back differs from write");
  unmapped_zero_a: assert property (param_req.addr == 8'h30 |=> param_rd_data == 16'h0000)
    else $error("unmapped index read nonzero");
  cover property (tick && pid_active);
  cover property (tick && !pid_active);
  cover property ($rose(source_conflict_alarm));
endmodule
bind pid_process_controller pid_process_controller_asserts #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_pid_process_controller_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .param_req(param_req), .param_rd_data(param_rd_data), .freq_cmd(freq_cmd),
  .freq_ref(freq_ref), .pid_active(pid_active), .source_conflict_alarm(source_conflict_alarm));
`default_nettype wire

// ---- process_plant.sv ----
// Behavioural process and drive model around the controller
`default_nettype none
module process_plant (
  // Bench controls
  input wire logic sys_clk,
  input wire logic [11:0] ai1_level,
  input wire logic [15:0] cmd_level,
  input wire logic run_level,
  // Controller side
  input wire logic signed [15:0] freq_ref,
  output logic [11:0] analog_input_one,
  output logic [11:0] analog_input_two,
  output logic [15:0] pulse_input,
  output logic [15:0] pulse_full_rate,
  output logic [3:0] pulse_filter_shift,
  output logic run,
  output logic [15:0] freq_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {analog_input_one, analog_input_two, pulse_input, run, freq_cmd} = '0;
  initial {pulse_full_rate, pulse_filter_shift} = {16'h03e8, 4'h0};
  // Speed sensor follows the reference; inputs move off the sampling edge
  always @(negedge sys_clk) begin
    analog_input_one <= ai1_level;
    analog_input_two <= (freq_ref < 0) ? 12'h000 : 12'(32'(freq_ref) * 4095 / 10000);
    pulse_input <= (freq_ref < 0) ? 16'h0000 : 16'(32'(freq_ref) / 10);
    run <= run_level;
    freq_cmd <= cmd_level;
  end
endmodule
`default_nettype wire

// ---- pid_process_controller_tb_top.sv ----
// Self-checking bench for the process controller
`default_nettype none
`include "pid_cfg.svh"
module pid_process_controller_tb_top;
  import pid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SAMP = 16;
  typedef struct {string name; logic [1:0] sel; logic [15:0] exp;} note_type;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  param_req_type param_req = '0;
  logic [15:0] param_rd_data, freq_cmd, pulse_input, pulse_full_rate, display_decimals;
  logic [15:0] display_unit;
  logic [15:0] cmd_level = 16'h0000;
  logic [11:0] analog_input_one, analog_input_two;
  logic [11:0] ai1_level = 12'h000;
  logic [3:0] pulse_filter_shift;
  logic run, pid_active, source_conflict_alarm;
  logic run_level = 1'b0;
  logic signed [15:0] freq_ref;
  logic [31:0] display_value;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 39893;
  note_type note_q[$];
  event seen;
  logic [7:0] rst_idx [10] = '{`IDX_SP_SEL, `IDX_FB_SEL, `IDX_FB_GAIN, `IDX_KP, `IDX_TI,
    `IDX_I_LIM, `IDX_O_LIM, `IDX_O_GAIN, `IDX_MODE, 8'h30};
  logic [15:0] rst_val [10] = '{16'h0001, 16'h0002, 16'h0064, 16'h0064, 16'h000a, 16'h03e8,
    16'h2710, 16'h000a, 16'h0000, 16'h0000};
  logic [7:0] src_idx [9] = '{`IDX_SP_SEL, `IDX_SP_SEL, `IDX_FB_SEL, `IDX_SP_SEL, `IDX_SP_SEL,
    `IDX_SP_SEL, `IDX_FB_SEL, `IDX_SP_SEL, `IDX_SP_SEL};
  logic [15:0] src_tab [9][2] = '{'{16'h0002, 16'h0001}, '{16'h0005, 16'h0001},
    '{16'h0003, 16'h0003}, '{16'h0002, 16'h0002}, '{16'h0004, 16'h0004},
    '{16'h0006, 16'h0006}, '{16'h0001, 16'h0001}, '{16'h0003, 16'h0003},
    '{16'h0004, 16'h0004}};
  logic [7:0] loop_idx [5] = '{`IDX_MODE, `IDX_KP, `IDX_REV, `IDX_O_LIM, `IDX_BIAS};
  // Columns: mode, gain, reverse permit, output clamp, bias, expected reference
  logic [15:0] loop_tab [7][6] = '{
    '{16'h0001, 16'h0064, 16'h0000, 16'h2710, 16'h0000, 16'h09c4},
    '{16'h0001, 16'h00c8, 16'h0000, 16'h2710, 16'h0000, 16'h1388},
    '{16'h0003, 16'h00c8, 16'h0000, 16'h2710, 16'h0000, 16'h0000},
    '{16'h0003, 16'h00c8, 16'h0001, 16'h2710, 16'h0000, 16'hec78},
    '{16'h0001, 16'h00c8, 16'h0000, 16'h0bb8, 16'h0000, 16'h0bb8},
    '{16'h0001, 16'h00c8, 16'h0000, 16'h2710, 16'h000a, 16'h1770},
    '{16'h0009, 16'h00c8, 16'h0000, 16'h2710, 16'h0000, 16'h1770}};

  always #2.5 sys_clk = ~sys_clk;

  pid_process_controller #(.ADC_W(12), .SAMPLE_CYCLES(SAMP)) u_pid_process_controller (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .param_req(param_req),
    .param_rd_data(param_rd_data), .analog_input_one(analog_input_one),
    .analog_input_two(analog_input_two), .pulse_input(pulse_input),
    .pulse_full_rate(pulse_full_rate), .pulse_filter_shift(pulse_filter_shift), .run(run),
    .freq_cmd(freq_cmd), .freq_ref(freq_ref), .pid_active(pid_active),
    .source_conflict_alarm(source_conflict_alarm), .display_value(display_value),
    .display_decimals(display_decimals), .display_unit(display_unit));
  process_plant u_process_plant (.sys_clk(sys_clk), .ai1_level(ai1_level),
    .cmd_level(cmd_level), .run_level(run_level), .freq_ref(freq_ref),
    .analog_input_one(analog_input_one), .analog_input_two(analog_input_two),
    .pulse_input(pulse_input), .pulse_full_rate(pulse_full_rate),
    .pulse_filter_shift(pulse_filter_shift), .run(run), .freq_cmd(freq_cmd));

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    param_req = '{1'b1, a, d};
    @(negedge sys_clk);
    param_req.wr = 1'b0;
  endtask
  // Notes the expectation, then signals once the result has settled
  // Source: 0 read-back, 1 reference, 2 display value, 3 display and status pins
  task automatic note(input logic [1:0] sel, input logic [7:0] a, input logic [15:0] e,
                      input string n);
    @(negedge sys_clk);
    param_req.addr = a;
    if (sel == 2'd1) repeat (3 * SAMP) @(negedge sys_clk);
    note_q.push_back('{n, sel, e});
    @(negedge sys_clk);
    -> seen;
  endtask

  always @(seen) begin
    note_type n;
    n = note_q.pop_front();
    check(n.name, (n.sel == 2'd1) ? freq_ref : (n.sel == 2'd2) ? display_value[15:0] :
          (n.sel == 2'd3) ? {display_unit[7:0], display_decimals[5:0], source_conflict_alarm,
          pid_active} : param_rd_data, n.exp);
  end

  initial begin
    logic [15:0] d;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 10; i++) note(2'd0, rst_idx[i], rst_val[i], "reset value");
    $display("test reset values done");
    wr(`IDX_SP_SEL, 16'h0002);
    note(2'd0, `IDX_STATUS, 16'h0002, "conflict status");
    note(2'd3, `IDX_STATUS, 16'h0006, "conflict pins");
    for (int i = 0; i < 9; i++) begin
      wr(src_idx[i], src_tab[i][0]);
      note(2'd0, src_idx[i], src_tab[i][1], "source select");
    end
    note(2'd0, `IDX_STATUS, 16'h0000, "cleared status");
    $display("test source select done");
    for (int i = 0; i < 4; i++) begin
      d = 16'($unsigned($random(seed)) % 1001);
      wr(`IDX_KP, d);
      note(2'd0, `IDX_KP, d, "gain readback");
    end
    $display("test gain access done");
    wr(`IDX_SP_INT, 16'h09c4);
    note(2'd2, `IDX_DISP_VAL, 16'h00fa, "display value");
    note(2'd0, `IDX_DISP_VAL, 16'h00fa, "display readback");
    wr(`IDX_TI, 16'h0000);
    cmd_level = 16'h03e8;
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 5; j++) wr(loop_idx[j], loop_tab[i][j]);
      run_level = (i == 6);
      note(2'd1, `IDX_REF, loop_tab[i][5], "loop reference");
    end
    note(2'd3, `IDX_REF, 16'h0005, "active pins");
    $display("test loop modes done");
    cmd_level = 16'($unsigned($random(seed)) % 10001);
    wr(`IDX_MODE, 16'h0000);
    note(2'd1, `IDX_REF, cmd_level, "bypass reference");
    note(2'd3, `IDX_REF, 16'h0004, "idle pins");
    $display("test bypass done");
    @(negedge sys_clk);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
`default_nettype wire
